// File: dtsr_regfile.sv
// Purpose: threshold, edge-rate and boost filter register file of the pre-driver controller
// Assumes: host and microcore requests are one-cycle strobes synchronous to clk_sys_i
// Notes: lock state, access grants and bootstrap overrides come from outside logic
`timescale 1ns/10ps
module dtsr_regfile
(
    input wire logic clk_sys_i, // system clock, 100 MHz
    input wire logic rst_n_i, // async reset, active low
    input wire logic host_wr_i, // host write strobe
    input wire logic host_rd_i, // host read strobe
    input wire logic [9:0] host_addr_i, // host register offset
    input wire logic [15:0] host_wdata_i, // host write data
    output logic [15:0] host_rdata_o, // host read data
    output logic host_rvalid_o, // read data valid pulse
    input wire logic uc_wr_i, // microcore backdoor write strobe
    input wire logic [1:0] uc_id_i, // requesting microcore
    input wire logic [9:0] uc_addr_i, // backdoor register offset
    input wire logic [15:0] uc_wdata_i, // backdoor write data
    output logic uc_done_o, // backdoor write accepted pulse
    output logic uc_reject_o, // backdoor write rejected pulse
    input wire logic cfg_lock_i, // lockable registers locked
    input wire logic [3:0][4:0] hs_output_access_grant_i, // per microcore high-side grants
    input wire logic [3:0][6:0] ls_output_access_grant_i, // per microcore low-side grants
    input wire logic [3:0] boost_dac_access_i, // per microcore boost converter grant
    input wire logic [4:0] bs_init_active_i, // bootstrap init per high-side
    input wire logic [14:0] bs_src_threshold_i, // init-phase source thresholds
    input wire logic boost_cmp_i, // raw boost comparator level
    output logic boost_fbk_o, // filtered boost comparator level
    output logic [14:0] hs_drain_source_threshold_o, // high-side drain-source thresholds
    output logic [14:0] hs_source_threshold_o, // effective high-side source thresholds
    output logic [17:0] ls_drain_source_threshold_o, // low-side drain-source thresholds
    output logic [9:0] hs_edge_rate_o, // high-side edge rates
    output logic [11:0] ls_edge_rate_o, // low-side 1..6 edge rates
    output logic [1:0] dcdc_lowside_driver_rise_o, // DC-DC driver rise rate
    output logic [1:0] dcdc_lowside_driver_fall_o // DC-DC driver fall rate
);

    ////////////////////////////////////////////////////////////////////////
    // decode and field-mask helpers

    function automatic logic [3:0] reg_decode(input logic [9:0] addr);
        logic [3:0] r;
        r = 4'h0;
        case (addr)
            dtsr_pkg::HS_DRAIN_SOURCE_LIMITS_OFS: r = {1'b1, dtsr_pkg::IDX_HS_DS};
            dtsr_pkg::HS_SOURCE_LIMITS_OFS: r = {1'b1, dtsr_pkg::IDX_HS_SRC};
            dtsr_pkg::LS_DRAIN_SOURCE_LIMITS_LOW_OFS: r = {1'b1, dtsr_pkg::IDX_LS_DS_LO};
            dtsr_pkg::LS_DRAIN_SOURCE_LIMITS_HIGH_OFS: r = {1'b1, dtsr_pkg::IDX_LS_DS_HI};
            dtsr_pkg::HS_EDGE_RATES_OFS: r = {1'b1, dtsr_pkg::IDX_HS_EDGE};
            dtsr_pkg::LS_EDGE_RATES_OFS: r = {1'b1, dtsr_pkg::IDX_LS_EDGE};
            dtsr_pkg::BOOST_FEEDBACK_FILTER_SETUP_OFS: r = {1'b1, dtsr_pkg::IDX_FILT};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // bits of fields whose output (first + field number) is granted
    function automatic logic [15:0] grant_mask(input logic [6:0] g, input int unsigned width,
                                               input int unsigned first, input int unsigned count);
        logic [15:0] m;
        m = 16'h0000;
        for (int unsigned b = 0; b < 16; b++)
        begin
            if ((b / width) < count && g[first + (b / width)])
            begin
                m[b] = 1'b1;
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] cfg_q [dtsr_pkg::NREG];
    logic [15:0] uc_mask;
    logic [3:0] host_dec;
    logic [3:0] uc_dec;
    logic [6:0] hs_g;
    logic [6:0] ls_g;
    logic uc_locked;
    logic uc_ok;
    logic [14:0] src_eff;
    logic [15:0] rd_val;

    assign host_dec = reg_decode(host_addr_i);
    assign uc_dec = reg_decode(uc_addr_i);
    assign hs_g = {2'b00, hs_output_access_grant_i[uc_id_i]};
    assign ls_g = ls_output_access_grant_i[uc_id_i];
    // only the filter setup is lockable
    assign uc_locked = cfg_lock_i && uc_dec[2:0] == dtsr_pkg::IDX_FILT;
    assign uc_ok = uc_wr_i && uc_dec[3] && !uc_locked;

    always_comb
    begin
        case (uc_dec[2:0])
            dtsr_pkg::IDX_HS_DS: uc_mask = grant_mask(hs_g, dtsr_pkg::THR_W, 0, 5);
            dtsr_pkg::IDX_HS_SRC: uc_mask = grant_mask(hs_g, dtsr_pkg::THR_W, 0, 5);
            dtsr_pkg::IDX_LS_DS_LO: uc_mask = grant_mask(ls_g, dtsr_pkg::THR_W, 0, 5);
            dtsr_pkg::IDX_LS_DS_HI: uc_mask = grant_mask(ls_g, dtsr_pkg::THR_W, 5, 1);
            dtsr_pkg::IDX_HS_EDGE: uc_mask = grant_mask(hs_g, dtsr_pkg::EDGE_W, 0, 5);
            // the DC-DC driver owns both top fields
            dtsr_pkg::IDX_LS_EDGE: uc_mask = grant_mask(ls_g, dtsr_pkg::EDGE_W, 0, 6)
                                           | {{4{ls_g[6]}}, 12'h000};
            dtsr_pkg::IDX_FILT: uc_mask = boost_dac_access_i[uc_id_i] ? 16'hffff : 16'h0000;
            default: uc_mask = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // storage; host write wins over a same-cycle backdoor write to the same register

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < dtsr_pkg::NREG; i++)
            begin
                cfg_q[i] <= dtsr_pkg::RESET_VAL[i];
            end
        end
        else
        begin
            for (int i = 0; i < dtsr_pkg::NREG; i++)
            begin
                if (host_wr_i && host_dec[3] && host_dec[2:0] == 3'(i)
                    && !(cfg_lock_i && 3'(i) == dtsr_pkg::IDX_FILT))
                begin
                    cfg_q[i] <= host_wdata_i & dtsr_pkg::WMASK[i];
                end
                else if (uc_ok && uc_dec[2:0] == 3'(i))
                begin
                    cfg_q[i] <= (cfg_q[i] & ~(uc_mask & dtsr_pkg::WMASK[i]))
                              | (uc_wdata_i & uc_mask & dtsr_pkg::WMASK[i]);
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            uc_done_o <= 1'b0;
            uc_reject_o <= 1'b0;
        end
        else
        begin
            uc_done_o <= uc_ok;
            uc_reject_o <= uc_wr_i && !uc_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective source thresholds: bootstrap init masks the stored value per driver

    always_comb
    begin
        for (int h = 0; h < dtsr_pkg::NHS; h++)
        begin
            src_eff[h*3 +: 3] = bs_init_active_i[h] ? bs_src_threshold_i[h*3 +: 3]
                                                    : cfg_q[dtsr_pkg::IDX_HS_SRC][h*3 +: 3];
        end
    end

    always_comb
    begin
        if (host_dec[2:0] == dtsr_pkg::IDX_HS_SRC)
        begin
            rd_val = {1'b0, src_eff};
        end
        else
        begin
            rd_val = cfg_q[host_dec[2:0]];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            host_rdata_o <= 16'h0000;
            host_rvalid_o <= 1'b0;
        end
        else
        begin
            host_rvalid_o <= host_rd_i;
            if (host_rd_i)
            begin
                // unmapped offsets read as zero
                host_rdata_o <= host_dec[3] ? rd_val : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the pre-drivers

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hs_source_threshold_o <= 15'h0000;
        end
        else
        begin
            hs_source_threshold_o <= src_eff;
        end
    end

    assign hs_drain_source_threshold_o = cfg_q[dtsr_pkg::IDX_HS_DS][14:0];
    assign ls_drain_source_threshold_o = {cfg_q[dtsr_pkg::IDX_LS_DS_HI][2:0],
                                          cfg_q[dtsr_pkg::IDX_LS_DS_LO][14:0]};
    assign hs_edge_rate_o = cfg_q[dtsr_pkg::IDX_HS_EDGE][9:0];
    assign ls_edge_rate_o = cfg_q[dtsr_pkg::IDX_LS_EDGE][11:0];
    assign dcdc_lowside_driver_fall_o =
        cfg_q[dtsr_pkg::IDX_LS_EDGE][dtsr_pkg::DCDC_FALL_LSB +: dtsr_pkg::EDGE_W];
    assign dcdc_lowside_driver_rise_o =
        cfg_q[dtsr_pkg::IDX_LS_EDGE][dtsr_pkg::DCDC_RISE_LSB +: dtsr_pkg::EDGE_W];

    ////////////////////////////////////////////////////////////////////////
    // boost feedback filter

    dtsr_filt_if fif ();

    assign fif.flt_len = cfg_q[dtsr_pkg::IDX_FILT][11:0];
    assign fif.flt_kind = cfg_q[dtsr_pkg::IDX_FILT][dtsr_pkg::FLT_KIND_BIT];
    assign fif.sample = boost_cmp_i;
    assign boost_fbk_o = fif.filtered;

    dtsr_boost_filter u_filter
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .fif(fif.filt)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_host_wr(logic [2:0] idx);
        host_wr_i && host_dec[3] && host_dec[2:0] == idx;
    endsequence

    sequence s_uc_only(logic [2:0] idx);
        uc_wr_i && uc_dec[3] && uc_dec[2:0] == idx && !host_wr_i;
    endsequence

    host_store_a: assert property (s_host_wr(dtsr_pkg::IDX_HS_DS)
        |=> hs_drain_source_threshold_o == $past(host_wdata_i[14:0]))
        else $error("host write to drain-source limits not stored");
    lock_reject_a: assert property ((s_uc_only(dtsr_pkg::IDX_FILT) ##0 cfg_lock_i)
        |=> $stable(cfg_q[dtsr_pkg::IDX_FILT]) && uc_reject_o)
        else $error("locked filter setup changed by backdoor");
    edge_ignore_a: assert property ((s_uc_only(dtsr_pkg::IDX_HS_EDGE) ##0 !hs_g[0])
        |=> $stable(hs_edge_rate_o[1:0]))
        else $error("ungranted edge field changed");
    edge_apply_a: assert property ((s_uc_only(dtsr_pkg::IDX_HS_EDGE) ##0 hs_g[1])
        |=> hs_edge_rate_o[3:2] == $past(uc_wdata_i[3:2]))
        else $error("granted edge field not applied");
    thr_grant_a: assert property ((s_uc_only(dtsr_pkg::IDX_LS_DS_HI) ##0 !ls_g[5])
        |=> $stable(ls_drain_source_threshold_o[17:15]))
        else $error("ungranted threshold field changed");
    boost_access_a: assert property ((s_uc_only(dtsr_pkg::IDX_FILT) ##0 !boost_dac_access_i[uc_id_i])
        |=> $stable(cfg_q[dtsr_pkg::IDX_FILT]))
        else $error("filter setup changed without converter access");
    src_read_a: assert property ((host_rd_i && host_dec[3] && host_dec[2:0] == dtsr_pkg::IDX_HS_SRC)
        |=> host_rvalid_o && host_rdata_o == {1'b0, $past(src_eff)})
        else $error("source threshold read not effective value");
    dcdc_split_a: assert property (s_host_wr(dtsr_pkg::IDX_LS_EDGE)
        |=> dcdc_lowside_driver_fall_o == $past(host_wdata_i[13:12])
            && dcdc_lowside_driver_rise_o == $past(host_wdata_i[15:14]))
        else $error("DC-DC rise and fall fields misplaced");
    uc_accept_a: assert property ((uc_wr_i && uc_dec[3] && !uc_locked) |=> uc_done_o && !uc_reject_o)
        else $error("unlocked backdoor write not accepted");
    dcdc_ignore_a: assert property ((s_uc_only(dtsr_pkg::IDX_LS_EDGE) ##0 !ls_g[6])
        |=> $stable({dcdc_lowside_driver_rise_o, dcdc_lowside_driver_fall_o}))
        else $error("ungranted DC-DC edge fields changed");
    thr_apply_a: assert property ((s_uc_only(dtsr_pkg::IDX_HS_SRC) ##0 hs_g[4])
        |=> cfg_q[dtsr_pkg::IDX_HS_SRC][14:12] == $past(uc_wdata_i[14:12]))
        else $error("granted source threshold field not applied");
    host_lock_a: assert property ((s_host_wr(dtsr_pkg::IDX_FILT) ##0 cfg_lock_i)
        |=> $stable(cfg_q[dtsr_pkg::IDX_FILT]))
        else $error("locked filter setup changed by host");

endmodule

// File: dtsr_pkg.sv
// Purpose: shared constants for the driver threshold and edge-rate register file
// Assumes: 16-bit registers reached at their printed 10-bit offsets
// Notes: storage index 0..6 maps to the offsets below in table order
package dtsr_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NREG = 7;
    localparam int unsigned NUC = 4;
    localparam int unsigned NHS = 5;
    localparam int unsigned NLS = 7;
    localparam int unsigned FLT_LEN_W = 12;

    // clock period of the filter time base
    localparam int unsigned TCK_NS = 10;

    localparam logic [9:0] HS_DRAIN_SOURCE_LIMITS_OFS = 10'h18a;
    localparam logic [9:0] HS_SOURCE_LIMITS_OFS = 10'h18b;
    localparam logic [9:0] LS_DRAIN_SOURCE_LIMITS_LOW_OFS = 10'h18c;
    localparam logic [9:0] LS_DRAIN_SOURCE_LIMITS_HIGH_OFS = 10'h18d;
    localparam logic [9:0] HS_EDGE_RATES_OFS = 10'h18e;
    localparam logic [9:0] LS_EDGE_RATES_OFS = 10'h18f;
    localparam logic [9:0] BOOST_FEEDBACK_FILTER_SETUP_OFS = 10'h19d;

    localparam logic [2:0] IDX_HS_DS = 3'h0;
    localparam logic [2:0] IDX_HS_SRC = 3'h1;
    localparam logic [2:0] IDX_LS_DS_LO = 3'h2;
    localparam logic [2:0] IDX_LS_DS_HI = 3'h3;
    localparam logic [2:0] IDX_HS_EDGE = 3'h4;
    localparam logic [2:0] IDX_LS_EDGE = 3'h5;
    localparam logic [2:0] IDX_FILT = 3'h6;

    // writable bits per register, reserved bits read as zero
    localparam logic [15:0] WMASK [NREG] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h0007,
                                            16'h03ff, 16'hffff, 16'h1fff};
    localparam logic [15:0] RESET_VAL [NREG] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                16'h0000, 16'h0000, 16'h0001};

    localparam int unsigned THR_W = 3;
    localparam int unsigned EDGE_W = 2;
    localparam int unsigned FLT_KIND_BIT = 12;
    localparam int unsigned DCDC_FALL_LSB = 12;
    localparam int unsigned DCDC_RISE_LSB = 14;

endpackage

// File: dtsr_filt_if.sv
// Purpose: carries filter setup and comparator levels between regfile and filter
// Assumes: single clock domain
// Notes: cfg side owns the setup, filt side owns the result
`timescale 1ns/10ps
interface dtsr_filt_if;
    logic [11:0] flt_len;
    logic flt_kind;
    logic sample;
    logic filtered;
    logic [11:0] count;

    modport cfg
    (
        output flt_len,
        output flt_kind,
        output sample,
        input filtered,
        input count
    );
    modport filt
    (
        input flt_len,
        input flt_kind,
        input sample,
        output filtered,
        output count
    );
endinterface

// File: dtsr_boost_filter.sv
// Purpose: digital glitch filter for the boost-voltage comparator feedback
// Assumes: comparator sample synchronous to clk_sys_i
// Notes: a sample counts as qualifying when it differs from the filtered level
`timescale 1ns/10ps
module dtsr_boost_filter
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    dtsr_filt_if.filt fif // setup in, result out
);

    logic [11:0] count_q;
    logic filt_q;
    logic differs;

    assign differs = fif.sample != filt_q;
    assign fif.filtered = filt_q;
    assign fif.count = count_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_q <= 12'h000;
            filt_q <= 1'b0;
        end
        else if (differs)
        begin
            if (count_q >= fif.flt_len)
            begin
                filt_q <= fif.sample;
                count_q <= 12'h000;
            end
            else
            begin
                count_q <= count_q + 12'h001;
            end
        end
        else if (!fif.flt_kind)
        begin
            count_q <= 12'h000;
        end
        else if (count_q != 12'h000)
        begin
            // decrement mode tolerates isolated glitches instead of restarting
            count_q <= count_q - 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_qual_run;
        fif.sample != filt_q;
    endsequence

    clear_mode_a: assert property ((!differs && !fif.flt_kind) |=> count_q == 12'h000)
        else $error("counter not cleared in clear mode");
    decrement_mode_a: assert property ((!differs && fif.flt_kind && count_q != 12'h000)
        |=> count_q == $past(count_q) - 12'h001)
        else $error("counter not decremented in decrement mode");
    flip_at_len_a: assert property ($changed(filt_q) |-> $past(count_q) >= $past(fif.flt_len))
        else $error("filtered level changed before length reached");
    zero_len_time_a: assert property ((fif.flt_len == 12'h000 && count_q == 12'h000
        && $stable(fif.flt_len) ##0 s_qual_run) |=> $changed(filt_q))
        else $error("zero length did not pass one qualifying cycle");
    one_len_time_a: assert property ((fif.flt_len == 12'h001 && count_q == 12'h000 ##0 s_qual_run)
        ##1 (fif.flt_len == 12'h001 ##0 s_qual_run) |=> $changed(filt_q))
        else $error("length one did not flip after two cycles");

endmodule

// File: dtsr_host_model.sv
// Purpose: host and microcore request source for the register file
// Assumes: requests launched by non-blocking assignment at rising edges
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module dtsr_host_model
(
    input wire logic clk_sys_i, // system clock
    output logic host_wr_o = 1'b0, // host write strobe
    output logic host_rd_o = 1'b0, // host read strobe
    output logic [9:0] host_addr_o = 10'h000, // host offset
    output logic [15:0] host_wdata_o = 16'h0000, // host data
    input wire logic [15:0] host_rdata_i, // host read data
    input wire logic host_rvalid_i, // read data valid
    output logic uc_wr_o = 1'b0, // backdoor strobe
    output logic [1:0] uc_id_o = 2'h0, // microcore number
    output logic [9:0] uc_addr_o = 10'h000, // backdoor offset
    output logic [15:0] uc_wdata_o = 16'h0000, // backdoor data
    input wire logic uc_done_i, // backdoor accepted
    input wire logic uc_reject_i // backdoor rejected
);
////////////////////////////////////////////////////////////////////////////////
task automatic write(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    host_wr_o <= 1'b1;
    host_addr_o <= a;
    host_wdata_o <= d;
    @(posedge clk_sys_i);
    host_wr_o <= 1'b0;
    host_addr_o <= ~a;
    host_wdata_o <= ~d;
endtask

task automatic read(input logic [9:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys_i);
    host_rd_o <= 1'b1;
    host_addr_o <= a;
    @(posedge clk_sys_i);
    host_rd_o <= 1'b0;
    host_addr_o <= ~a;
    // answer stands for one cycle after the taking edge
    #1;
    d = host_rdata_i;
    v = host_rvalid_i;
endtask

task automatic ucw(input logic [1:0] id, input logic [9:0] a, input logic [15:0] d, output logic dn, output logic rj);
    @(posedge clk_sys_i);
    uc_wr_o <= 1'b1;
    uc_id_o <= id;
    uc_addr_o <= a;
    uc_wdata_o <= d;
    @(posedge clk_sys_i);
    uc_wr_o <= 1'b0;
    uc_id_o <= ~id;
    uc_addr_o <= ~a;
    uc_wdata_o <= ~d;
    #1;
    dn = uc_done_i;
    rj = uc_reject_i;
endtask
endmodule

// File: tb.sv
// Purpose: self-checking bench for the threshold and edge-rate register file
// Assumes: one 100 MHz clock, reset held for three cycles
// Notes: a reference filter runs beside the design from reset onwards
`timescale 1ns/10ps
module tb;
logic clk_sys_i = 1'b0;
logic rst_n_i = 1'b0;
logic host_wr, host_rd, host_rvalid, uc_wr, uc_done, uc_reject, fbk;
logic [9:0] host_addr, uc_addr, hs_er;
logic [15:0] host_rdata, host_wdata, uc_wdata;
logic [1:0] uc_id, rise, fall;
logic cfg_lock = 1'b0;
logic [3:0][4:0] hs_gr = '0;
logic [3:0][6:0] ls_gr = '0;
logic [3:0] dac_acc = 4'h0;
logic [4:0] bs_act = 5'h00;
logic [14:0] bs_thr = 15'h0000, hs_ds, hs_src;
logic [17:0] ls_ds;
logic [11:0] ls_er, m_len, m_cnt;
logic cmp = 1'b0;
logic m_out, m_kind;
logic [15:0] shd [7];
int n_errors = 0;
int compares = 0;
localparam logic [9:0] OFS [8] = '{10'h18a, 10'h18b, 10'h18c, 10'h18d, 10'h18e, 10'h18f, 10'h19d, 10'h1a0};

always #5 clk_sys_i = ~clk_sys_i;

dtsr_host_model host (.clk_sys_i(clk_sys_i), .host_wr_o(host_wr), .host_rd_o(host_rd), .host_addr_o(host_addr),
    .host_wdata_o(host_wdata), .host_rdata_i(host_rdata), .host_rvalid_i(host_rvalid), .uc_wr_o(uc_wr),
    .uc_id_o(uc_id), .uc_addr_o(uc_addr), .uc_wdata_o(uc_wdata), .uc_done_i(uc_done), .uc_reject_i(uc_reject));

dtsr_regfile DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_wr_i(host_wr), .host_rd_i(host_rd),
    .host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_rdata_o(host_rdata), .host_rvalid_o(host_rvalid),
    .uc_wr_i(uc_wr), .uc_id_i(uc_id), .uc_addr_i(uc_addr), .uc_wdata_i(uc_wdata), .uc_done_o(uc_done),
    .uc_reject_o(uc_reject), .cfg_lock_i(cfg_lock), .hs_output_access_grant_i(hs_gr),
    .ls_output_access_grant_i(ls_gr), .boost_dac_access_i(dac_acc), .bs_init_active_i(bs_act),
    .bs_src_threshold_i(bs_thr), .boost_cmp_i(cmp), .boost_fbk_o(fbk), .hs_drain_source_threshold_o(hs_ds),
    .hs_source_threshold_o(hs_src), .ls_drain_source_threshold_o(ls_ds), .hs_edge_rate_o(hs_er),
    .ls_edge_rate_o(ls_er), .dcdc_lowside_driver_rise_o(rise), .dcdc_lowside_driver_fall_o(fall));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
        n_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask

task automatic finish_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask

function automatic logic [15:0] eff_src();
    logic [15:0] v;
    v = shd[1];
    for (int i = 0; i < 5; i++)
        if (bs_act[i])
            v[3*i+:3] = bs_thr[3*i+:3];
    return v;
endfunction

// only granted fields take the new bits
function automatic logic [15:0] gate(input logic [15:0] o, input logic [15:0] d, input int fw, input logic [7:0] g);
    logic [15:0] v;
    v = o;
    for (int i = 0; i < 8; i++)
        for (int b = 0; b < fw; b++)
            if (g[i] && i * fw + b < 16)
                v[i*fw+b] = d[i*fw+b];
    return v;
endfunction

function automatic logic [15:0] exp_uc(input int idx, input int id, input logic [15:0] d);
    logic [15:0] o;
    o = shd[idx];
    case (idx)
        0, 1: o = gate(o, d, 3, {3'h0, hs_gr[id]});
        2: o = gate(o, d, 3, {1'b0, ls_gr[id]});
        3: o = gate(o, d, 3, {7'h00, ls_gr[id][5]});
        4: o = gate(o, d, 2, {3'h0, hs_gr[id]});
        5: o = gate(o, d, 2, {ls_gr[id][6], ls_gr[id]});
        default: o = dac_acc[id] ? d : o;
    endcase
    return o & dtsr_pkg::WMASK[idx];
endfunction

task automatic check_all();
    logic [15:0] d, e;
    logic v;
    e = eff_src();
    for (int i = 0; i < 8; i++)
    begin
        host.read(OFS[i], d, v);
        chk(v, 1'b1);
        chk(d, i == 7 ? 16'h0000 : (i == 1 ? e : shd[i]));
    end
    chk(hs_ds, shd[0][14:0]);
    chk(hs_src, e[14:0]);
    chk(ls_ds, {shd[3][2:0], shd[2][14:0]});
    chk(hs_er, shd[4][9:0]);
    chk(ls_er, shd[5][11:0]);
    chk({rise, fall}, shd[5][15:12]);
endtask
////////////////////////////////////////////////////////////////////////////////
// reference filter, pre-edge values seen in the active region
always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        m_out = 1'b0;
        m_cnt = 12'h000;
        m_len = 12'h001;
        m_kind = 1'b0;
    end
    else
    begin
        chk(fbk, m_out);
        if (cmp != m_out)
        begin
            if (m_cnt >= m_len)
            begin
                m_out = ~m_out;
                m_cnt = 12'h000;
            end
            else
                m_cnt = m_cnt + 12'h001;
        end
        else if (m_kind)
            m_cnt = (m_cnt == 12'h000) ? 12'h000 : m_cnt - 12'h001;
        else
            m_cnt = 12'h000;
        if (host_wr && host_addr == 10'h19d && !cfg_lock)
            {m_kind, m_len} = host_wdata[12:0];
        else if (uc_wr && uc_addr == 10'h19d && !cfg_lock && dac_acc[uc_id])
            {m_kind, m_len} = uc_wdata[12:0];
    end
end

initial
begin
    #200000;
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
end

initial
begin
    int idx, id, len;
    logic [15:0] d;
    logic lk, dn, rj;
    idx = $urandom(75900);
    for (int i = 0; i < 7; i++)
        shd[i] = dtsr_pkg::RESET_VAL[i];
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    check_all();
    $display("test reset done");
    repeat (20)
    begin
        idx = $urandom_range(6);
        d = 16'($urandom);
        lk = 1'($urandom_range(1));
        @(posedge clk_sys_i) cfg_lock <= lk;
        host.write(OFS[idx], d);
        if (!(idx == 6 && lk))
            shd[idx] = d & dtsr_pkg::WMASK[idx];
        check_all();
    end
    $display("test host writes done");
    repeat (4)
    begin
        @(posedge clk_sys_i);
        bs_act <= 5'($urandom);
        bs_thr <= 15'($urandom);
        // let the new override values land before the expectation is formed
        @(posedge clk_sys_i);
        check_all();
    end
    @(posedge clk_sys_i) bs_act <= 5'h00;
    $display("test bootstrap override done");
    repeat (30)
    begin
        id = $urandom_range(3);
        idx = $urandom_range(7);
        d = 16'($urandom);
        lk = 1'($urandom_range(1));
        @(posedge clk_sys_i);
        cfg_lock <= lk;
        hs_gr <= 20'($urandom);
        ls_gr <= 28'($urandom);
        dac_acc <= 4'($urandom);
        host.ucw(id[1:0], OFS[idx], d, dn, rj);
        lk = (idx == 7) || (idx == 6 && lk);
        chk(rj, lk);
        chk(dn, !lk);
        if (!lk)
            shd[idx] = exp_uc(idx, id, d);
        check_all();
    end
    $display("test backdoor done");
    @(posedge clk_sys_i) cfg_lock <= 1'b0;
    // lengths zero to three in both counter kinds
    foreach (OFS[k])
    begin
        d = 16'(k % 4) | (k >= 4 ? 16'h1000 : 16'h0000);
        host.write(10'h19d, d);
        shd[6] = d;
        repeat (25)
        begin
            lk = 1'($urandom_range(1));
            len = $urandom_range(6, 1);
            repeat (len) @(posedge clk_sys_i) cmp <= lk;
        end
    end
    check_all();
    $display("test filter done");
    finish_test();
end
endmodule
